/* File: dv/adccal_ctrl_asserts.sv */
// port-level assertions for the calibration sequencing block
`timescale 1ns/1ns
module adccal_ctrl_chk
  import adccal_pkg::*;
(
  input wire logic                          clk_in,
  input wire logic                          rst_n_in,
  input wire logic [adccal_pkg::ADDR_W-1:0] addr_in,
  input wire logic [adccal_pkg::DATA_W-1:0] wdata_in,
  input wire logic                          wr_in,
  input wire logic                          rd_in,
  input wire logic [adccal_pkg::WORD_W-1:0] sample_in,
  input wire logic [adccal_pkg::DATA_W-1:0] rdata_out,
  input wire logic                          result_ready_flag_out,
  input wire logic [2:0]                    chan_out,
  input wire logic [2:0]                    gain_out,
  input wire logic                          short_inputs_out,
  input wire logic                          ref_over_gain_out,
  input wire logic                          irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire ctrl_wr = wr_in && (addr_in == ADDR_CTRL);
  property p_rd_idle; !rd_in |=> rdata_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
  property p_zs_start;
    ctrl_wr && wdata_in[5:3] == MODE_ZS_CAL |=> short_inputs_out && !ref_over_gain_out && result_ready_flag_out
      && chan_out == $past(wdata_in[2:0]) && gain_out == $past(wdata_in[8:6]);
  endproperty
  a_zs_start: assert property (p_zs_start) else $error("zero-scale start wrong");
  property p_fs_start;
    ctrl_wr && wdata_in[5:3] == MODE_FS_CAL |=> ref_over_gain_out && !short_inputs_out && result_ready_flag_out;
  endproperty
  a_fs_start: assert property (p_fs_start) else $error("full-scale start wrong");
  property p_bg_start; ctrl_wr && wdata_in[5:3] == MODE_BG_CAL |=> short_inputs_out && !ref_over_gain_out; endproperty
  a_bg_start: assert property (p_bg_start) else $error("background zero step missing");
  property p_hold; !ctrl_wr |=> $stable(chan_out) && $stable(gain_out); endproperty
  a_hold: assert property (p_hold) else $error("channel or gain moved mid sequence");
  property p_excl; !(short_inputs_out && ref_over_gain_out); endproperty
  a_excl: assert property (p_excl) else $error("both calibration sources on");
  // cycles the present calibration source has been on; a step begun by a write lasts one cycle more
  logic [11:0] src_len_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      src_len_reg <= 12'h000;
    end
    else if (short_inputs_out || ref_over_gain_out)
    begin
      src_len_reg <= src_len_reg + 12'h001;
    end
    else
    begin
      src_len_reg <= 12'h000;
    end
  end
  // one step only: the source must drop after a single step length
  property p_fs_len; $fell(ref_over_gain_out) |-> src_len_reg == 12'h3E8 || src_len_reg == 12'h3E9; endproperty
  a_fs_len: assert property (p_fs_len) else $error("full-scale step length wrong");
  property p_zs_len; $fell(short_inputs_out) |-> src_len_reg == 12'h3E8 || src_len_reg == 12'h3E9; endproperty
  a_zs_len: assert property (p_zs_len) else $error("zero-scale step length wrong");
  // in background mode the next zero step starts on the very edge that delivers the word
  property p_flag_fell;
    $fell(result_ready_flag_out) |-> !$past(short_inputs_out) && !$past(ref_over_gain_out);
  endproperty
  a_flag_fell: assert property (p_flag_fell) else $error("ready fell during calibration");
  c_zs: cover property (ctrl_wr && wdata_in[5:3] == MODE_ZS_CAL);
  c_fs: cover property (ctrl_wr && wdata_in[5:3] == MODE_FS_CAL);
  c_bg: cover property (ctrl_wr && wdata_in[5:3] == MODE_BG_CAL);
endmodule : adccal_ctrl_chk
bind adccal_ctrl adccal_ctrl_chk i_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .sample_in,
  .rdata_out, .result_ready_flag_out, .chan_out, .gain_out, .short_inputs_out, .ref_over_gain_out, .irq_out);

/* File: dv/adccal_filter_model.sv */
// filter output stand-in: a word that changes every cycle
`timescale 1ns/1ns
module adccal_filter_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  output logic      [23:0] sample_out
);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sample_out <= 24'h5A5A5A;
    else
      sample_out <= sample_out + 24'h010101;
  end
endmodule : adccal_filter_model

/* File: dv/tb.sv */
// self-checking bench for the calibration sequencing block
`timescale 1ns/1ns
module tb;
  import adccal_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} adccal_row_t;
  logic        clk_in, rst_n_in, wr_in, rd_in, flag, sh, refg, irq;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, q, keep;
  logic [23:0] sample;
  logic [2:0]  chan, gain, md;
  int          bad_count, check_count, n;
  adccal_row_t rows [10];
  adccal_filter_model i_filt (.clk_in, .rst_n_in, .sample_out(sample));
  adccal_ctrl i_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .sample_in(sample), .rdata_out,
    .result_ready_flag_out(flag), .chan_out(chan), .gain_out(gain), .short_inputs_out(sh),
    .ref_over_gain_out(refg), .irq_out(irq));
  task summarize;
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; a cycle passes between accesses so no strobe is assigned twice in one step
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1 q = rdata_out;
  endtask : bus
  function logic pick(input int s);
    return (s == 0) ? sh : (s == 1) ? refg : flag;
  endfunction : pick
  task wt(input int s, input logic lvl);
    n = 0;
    while (pick(s) !== lvl && n < 6000)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 6000)
      chk(32'h0, 32'h1);
  endtask : wt
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (40000) @(posedge clk_in);
    bad_count++;
    summarize();
  end
  initial
  begin
    rst_n_in = 1'b0;
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    rows = '{'{1'b0, ADDR_CTRL, 32'h0}, '{1'b0, ADDR_MASK, 32'h0}, '{1'b1, ADDR_MASK, 32'h7},
      '{1'b0, ADDR_MASK, 32'h7}, '{1'b1, 8'h40, 32'hFF}, '{1'b0, 8'h40, 32'h0}, '{1'b1, ADDR_STATE, 32'h1F},
      '{1'b0, ADDR_STATE, 32'h10}, '{1'b1, ADDR_CTRL, 32'hC3}, '{1'b0, ADDR_CTRL, 32'hC3}};
    repeat (2) @(posedge clk_in);
    chk({25'h0, flag, sh, refg, irq, chan[1:0], gain[0]}, 32'h40);
    rst_n_in <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(q, rows[i].d);
    end
    // zero-scale then full-scale, both on channel 5 at gain 2
    for (int m = 0; m < 2; m++)
    begin
      md = m ? MODE_FS_CAL : MODE_ZS_CAL;
      bus(1'b0, m ? ADDR_FULL : ADDR_OFFSET, 32'h0);
      keep = q;
      bus(1'b0, ADDR_STATUS, 32'h0);
      bus(1'b1, ADDR_CTRL, {23'h0, 3'h2, md, 3'h5});
      chk({23'h0, sh, refg, flag, chan, gain}, {23'h0, m == 0, m == 1, 1'b1, 3'h5, 3'h2});
      wt(m, 1'b0);
      chk(n >= 995 && n <= 1001, 32'h1);
      bus(1'b0, m ? ADDR_FULL : ADDR_OFFSET, 32'h0);
      chk({31'h0, q != keep}, 32'h1);
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(q, {23'h0, 3'h2, MODE_NORMAL, 3'h5});
      wt(2, 1'b0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h3);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, ADDR_DATA, 32'h0);
      chk({31'h0, flag}, 32'h1);
    end
    // background mode only after both self-calibrations have run
    bus(1'b0, ADDR_OFFSET, 32'h0);
    keep = q;
    bus(1'b1, ADDR_CTRL, {23'h0, 3'h2, MODE_BG_CAL, 3'h5});
    chk({30'h0, sh, refg}, 32'h2);
    wt(0, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h4, 32'h4);
    bus(1'b0, ADDR_OFFSET, 32'h0);
    chk({31'h0, q != keep}, 32'h1);
    wt(2, 1'b0);
    chk(n >= 4900 && n <= 5100, 32'h1);
    wt(0, 1'b1);
    chk(n < 3, 32'h1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, {23'h0, 3'h2, MODE_BG_CAL, 3'h5});
    // reset in mid-step must drop sources, irq and selection at once and raise the flag
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    #1 chk({25'h0, flag, sh, refg, irq, chan[1:0], gain[0]}, 32'h40);
    summarize();
  end
endmodule : tb

/* File: include/adccal_pkg.sv */
// constants shared by the calibration sequencing logic
package adccal_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned WORD_W      = 24;
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_MASK   = 8'h08;
  localparam logic [7:0]  ADDR_DATA   = 8'h0C;
  localparam logic [7:0]  ADDR_OFFSET = 8'h10;
  localparam logic [7:0]  ADDR_FULL   = 8'h14;
  localparam logic [7:0]  ADDR_STATE  = 8'h18;
  // control register fields
  localparam int unsigned CHAN_LSB    = 0;
  localparam int unsigned MODE_LSB    = 3;
  localparam int unsigned GAIN_LSB    = 6;
  // status / mask bit positions
  localparam int unsigned EV_CAL_DONE = 0;
  localparam int unsigned EV_WORD     = 1;
  localparam int unsigned EV_BG_COEF  = 2;
  localparam int unsigned EV_W        = 3;
  // operating mode codes
  localparam logic [2:0]  MODE_NORMAL = 3'h0;
  localparam logic [2:0]  MODE_BG_CAL = 3'h5;
  localparam logic [2:0]  MODE_ZS_CAL = 3'h6;
  localparam logic [2:0]  MODE_FS_CAL = 3'h7;
  // one conversion or calibration step
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned STEP_NS     = 50_000;
  localparam int unsigned STEP_CYCLES = (STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned STEP_W      = 12;
  // background words: one zero-scale step plus five conversion steps
  localparam logic [2:0]  BG_STEPS    = 3'h6;
  localparam logic [8:0]  RESET_CTRL  = 9'h000;
  localparam logic        RESET_FLAG  = 1'b1;
  typedef enum logic [1:0] {ST_CONV, ST_SELF_ZERO, ST_SELF_FULL, ST_BG_ZERO} adccal_state_t;
endpackage : adccal_pkg

/* File: rtl/adccal_ctrl.sv */
// calibration mode sequencing with register port and interrupt
//
// Notes on behaviour
// RQ1 - background mode adds an offset step per word, word rate one sixth.
// RQ2 - background mode interleaves zero-scale steps and updates offset coefficient itself.
// RQ3 - background zero-scale step uses shorted inputs at the selected gain.
// RQ4 - host should self-calibrate first; background never does full-scale.
// RQ5 - zero-scale self-cal calibrates selected channel and gain on shorted inputs.
// RQ6 - full-scale self-cal uses reference over gain on selected channel.
// RQ7 - self-cal is one step, then mode bits return to 000, normal mode.
// RQ8 - ready flag high at calibration start, low when calibration done and word ready.
// RQ9 - channel and gain are latched at mode write, held through calibration.
`timescale 1ns/1ns
module adccal_ctrl
  import adccal_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [adccal_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [adccal_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  input  wire logic [adccal_pkg::WORD_W-1:0] sample_in,
  output logic      [adccal_pkg::DATA_W-1:0] rdata_out,
  output logic                               result_ready_flag_out,
  output logic      [2:0]                    chan_out,
  output logic      [2:0]                    gain_out,
  output logic                               short_inputs_out,
  output logic                               ref_over_gain_out,
  output logic                               irq_out
);
  import adccal_pkg::*;

  adccal_state_t     state_reg;
  adccal_state_t     state_next;
  logic [2:0]        mode_reg;
  logic [2:0]        chan_sel_reg;
  logic [2:0]        gain_sel_reg;
  logic [2:0]        bg_count_reg;
  logic [WORD_W-1:0] data_reg;
  logic [WORD_W-1:0] offset_coef_reg;
  logic [WORD_W-1:0] full_coef_reg;
  logic [EV_W-1:0]   status_reg;
  logic [EV_W-1:0]   status_next;
  logic [EV_W-1:0]   mask_reg;
  logic [EV_W-1:0]   events;
  logic              step_done;
  logic              ctrl_wr;
  logic              word_out;
  logic              cal_start;
  logic [2:0]        mode_wr;

  assign ctrl_wr = wr_in && (addr_in == ADDR_CTRL);
  assign mode_wr = wdata_in[MODE_LSB +: 3];
  assign cal_start = ctrl_wr && (mode_wr == MODE_ZS_CAL || mode_wr == MODE_FS_CAL);

  // a control write restarts the step so a calibration always gets a full step
  adccal_step_timer #(
    .STEPS (STEP_CYCLES),
    .W     (STEP_W)
  ) u_step (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .restart_in    (ctrl_wr),
    .step_done_out (step_done)
  );

  // in background mode only the sixth step delivers a word
  always_comb
  begin
    word_out = 1'b0;
    if (!ctrl_wr && step_done && state_reg == ST_CONV)
    begin
      // the zero step is one of the six, so the fifth conversion step delivers the word
      word_out = (mode_reg != MODE_BG_CAL) || (bg_count_reg == BG_STEPS - 3'h2); // see RQ1
    end
  end

  always_comb
  begin
    state_next = state_reg;
    if (ctrl_wr)
    begin
      unique case (mode_wr)
        MODE_ZS_CAL: state_next = ST_SELF_ZERO; // see RQ5
        MODE_FS_CAL: state_next = ST_SELF_FULL; // see RQ6
        MODE_BG_CAL: state_next = ST_BG_ZERO;   // see RQ2
        default:     state_next = ST_CONV;
      endcase
    end
    else if (step_done)
    begin
      unique case (state_reg)
        ST_SELF_ZERO: state_next = ST_CONV; // see RQ7
        ST_SELF_FULL: state_next = ST_CONV; // see RQ7
        ST_BG_ZERO:   state_next = ST_CONV; // see RQ2
        ST_CONV:      state_next = (word_out && mode_reg == MODE_BG_CAL) ? ST_BG_ZERO : ST_CONV; // see RQ1
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg         <= ST_CONV;
      short_inputs_out  <= 1'b0;
      ref_over_gain_out <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      short_inputs_out  <= (state_next == ST_SELF_ZERO) || (state_next == ST_BG_ZERO); // see RQ3
      ref_over_gain_out <= (state_next == ST_SELF_FULL); // see RQ6
    end
  end

  // mode field: written by software, cleared by hardware after a self-cal
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_reg     <= RESET_CTRL[MODE_LSB +: 3];
      chan_sel_reg <= RESET_CTRL[CHAN_LSB +: 3];
      gain_sel_reg <= RESET_CTRL[GAIN_LSB +: 3];
    end
    else if (ctrl_wr)
    begin
      mode_reg     <= mode_wr;
      chan_sel_reg <= wdata_in[CHAN_LSB +: 3]; // see RQ9
      gain_sel_reg <= wdata_in[GAIN_LSB +: 3]; // see RQ9
    end
    else if (step_done && (state_reg == ST_SELF_ZERO || state_reg == ST_SELF_FULL))
    begin
      mode_reg <= MODE_NORMAL; // see RQ7
    end
  end

  // front end sees only the latched selection, never a half-written one
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chan_out <= RESET_CTRL[CHAN_LSB +: 3];
      gain_out <= RESET_CTRL[GAIN_LSB +: 3];
    end
    else if (ctrl_wr)
    begin
      chan_out <= wdata_in[CHAN_LSB +: 3]; // see RQ5
      gain_out <= wdata_in[GAIN_LSB +: 3]; // see RQ3
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bg_count_reg <= 3'h0;
    end
    else if (ctrl_wr || (step_done && state_reg == ST_BG_ZERO) || word_out)
    begin
      bg_count_reg <= 3'h0;
    end
    else if (step_done && state_reg == ST_CONV)
    begin
      bg_count_reg <= bg_count_reg + 3'h1; // see RQ1
    end
  end

  // coefficients and data are taken from the filter output at step end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_reg        <= '0;
      offset_coef_reg <= '0;
      full_coef_reg   <= '0;
    end
    else if (!ctrl_wr && step_done)
    begin
      if (state_reg == ST_SELF_ZERO || state_reg == ST_BG_ZERO)
      begin
        offset_coef_reg <= sample_in; // see RQ2
      end
      if (state_reg == ST_SELF_FULL)
      begin
        full_coef_reg <= sample_in; // see RQ6
      end
      if (word_out)
      begin
        data_reg <= sample_in;
      end
    end
  end

  // flag stays high from calibration start through the following conversion
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      result_ready_flag_out <= RESET_FLAG;
    end
    else if (cal_start)
    begin
      result_ready_flag_out <= 1'b1; // see RQ8
    end
    else if (word_out)
    begin
      result_ready_flag_out <= 1'b0; // see RQ8
    end
    else if (rd_in && addr_in == ADDR_DATA)
    begin
      result_ready_flag_out <= 1'b1;
    end
  end

  always_comb
  begin
    events = '0;
    events[EV_CAL_DONE] = !ctrl_wr && step_done && (state_reg == ST_SELF_ZERO || state_reg == ST_SELF_FULL);
    events[EV_WORD]     = word_out;
    events[EV_BG_COEF]  = !ctrl_wr && step_done && (state_reg == ST_BG_ZERO);
  end

  // an event in the reading cycle survives the clear
  always_comb
  begin
    status_next = status_reg;
    if (rd_in && addr_in == ADDR_STATUS)
    begin
      status_next = '0;
    end
    status_next = status_next | events;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status_reg <= '0;
      mask_reg   <= '0;
      irq_out    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_out    <= |(status_next & (wr_in && addr_in == ADDR_MASK ? wdata_in[EV_W-1:0] : mask_reg));
      if (wr_in && addr_in == ADDR_MASK)
      begin
        mask_reg <= wdata_in[EV_W-1:0];
      end
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= '0;
    end
    else if (rd_in)
    begin
      unique case (addr_in)
        ADDR_CTRL:   rdata_out <= {23'h0, gain_sel_reg, mode_reg, chan_sel_reg};
        ADDR_STATUS: rdata_out <= {29'h0, status_reg};
        ADDR_MASK:   rdata_out <= {29'h0, mask_reg};
        ADDR_DATA:   rdata_out <= {8'h00, data_reg};
        ADDR_OFFSET: rdata_out <= {8'h00, offset_coef_reg};
        ADDR_FULL:   rdata_out <= {8'h00, full_coef_reg};
        ADDR_STATE:  rdata_out <= {24'h0, bg_count_reg, result_ready_flag_out, 2'(state_reg), 2'h0};
        default:     rdata_out <= '0;
      endcase
    end
    else
    begin
      rdata_out <= '0;
    end
  end
endmodule : adccal_ctrl

/* File: rtl/adccal_step_timer.sv */
// step timer: one-cycle enable at the end of each conversion step
`timescale 1ns/1ns
module adccal_step_timer #(
  parameter int unsigned STEPS = 1000,
  parameter int unsigned W     = 12
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic restart_in,
  output logic      step_done_out
);
  logic [W-1:0] count_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_reg     <= '0;
      step_done_out <= 1'b0;
    end
    else if (restart_in)
    begin
      count_reg     <= '0;
      step_done_out <= 1'b0;
    end
    else if (count_reg == W'(STEPS - 1))
    begin
      count_reg     <= '0;
      step_done_out <= 1'b1;
    end
    else
    begin
      count_reg     <= count_reg + W'(1);
      step_done_out <= 1'b0;
    end
  end
endmodule : adccal_step_timer
